// >>> hw/sabt_buf_ram.sv
// Single-port buffer RAM with registered read data.
`timescale 1ns/1ps
`default_nettype none
module sabt_buf_ram #(
  parameter int AW    = 5,
  parameter int DW    = 8,
  parameter int DEPTH = 32
) (
  // Clock.
  input  wire logic          clk,
  // Access port.
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  import sabt_pkg::*;

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_d;

  always_comb begin
    rdata_d = rdata;
    if (en && !we) begin
      rdata_d = mem[addr];
    end
  end

  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    rdata <= rdata_d;
  end

endmodule : sabt_buf_ram
`default_nettype wire

// >>> hw/sabt_pkg.sv
// Shared constants, carrier structs and state codes of the serial block-transfer engine.
package sabt_pkg;

  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int BCNT_W  = 3;
  localparam int IVL_W   = 8;
  localparam int RAM_DEP = 32;

  localparam logic [ADDR_W-1:0] ADDR_RST  = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 5'h01;
  localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;
  localparam logic [IVL_W-1:0]  IVL_RST   = 8'h00;
  localparam logic [IVL_W-1:0]  IVL_ONE   = 8'h01;
  localparam logic [BCNT_W-1:0] BCNT_RST  = 3'h0;
  localparam logic [BCNT_W-1:0] BCNT_ONE  = 3'h1;
  localparam logic [BCNT_W-1:0] BCNT_LAST = 3'h7;

  typedef struct packed {
    logic iface_enable;
    logic auto_mode_sel;
    logic repeat_sel;
    logic tx_enable;
    logic rx_enable;
    logic bit_order_sel;
  } sabt_cfg_s;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sabt_cpu_req_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_PUT   = 3'h3,
    ST_SEND  = 3'h2,
    ST_STORE = 3'h6,
    ST_GAP   = 3'h7
  } sabt_state_e;

endpackage : sabt_pkg

// >>> hw/sabt_top.sv
// Automatic block-transfer clocked-serial unit: engine, buffer arbiter and link shifter.
`timescale 1ns/1ps
`default_nettype none
module sabt_top (
  // System clock and reset.
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // Serial link pins.
  input  wire logic                          SERIAL_CLOCK_PIN,
  input  wire logic                          SERIAL_IN_PIN,
  output logic                               SERIAL_OUT_PIN,
  output logic                               SI_RELEASED,
  // Control bits and triggers.
  input  wire sabt_pkg::sabt_cfg_s           CFG,
  input  wire logic                          START_TRIGGER,
  input  wire logic                          SUSPEND_TRIGGER,
  input  wire logic [sabt_pkg::ADDR_W-1:0]   XFER_END_POINTER,
  input  wire logic [sabt_pkg::IVL_W-1:0]    XFER_INTERVAL_REG,
  input  wire logic                          CPU_HALT,
  // CPU buffer port.
  input  wire sabt_pkg::sabt_cpu_req_s       CPU_REQ,
  output logic                               CPU_WAIT,
  output logic                               CPU_RVALID,
  output logic      [sabt_pkg::DATA_W-1:0]   CPU_RDATA,
  // Status and interrupt.
  output logic                               XFER_IN_PROGRESS,
  output logic      [sabt_pkg::ADDR_W-1:0]   XFER_ADDR_COUNTER,
  output logic                               AUTO_XFER_IRQ_FLAG,
  output logic                               AUTO_XFER_IRQ,
  input  wire logic                          IRQ_FLAG_CLR
);
  import sabt_pkg::*;

  // Engine state in the system clock domain.
  sabt_state_e       state_q,     state_d;
  logic [ADDR_W-1:0] addr_q,      addr_d;
  logic              busy_q,      busy_d;
  logic              irq_flag_q,  irq_flag_d;
  logic              irq_q,       irq_d;
  logic              susp_q,      susp_d;
  logic [DATA_W-1:0] tx_hold_q,   tx_hold_d;
  logic              req_q,       req_d;
  logic [IVL_W-1:0]  ivl_q,       ivl_d;
  logic              rvalid_q,    rvalid_d;
  logic              ack_s1_q;
  logic              ack_s2_q;

  // Buffer port signals.
  logic              eng_rd;
  logic              eng_wr;
  logic              ram_en;
  logic              ram_we;
  logic [ADDR_W-1:0] ram_addr;
  logic [DATA_W-1:0] ram_wdata;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] rx_ordered;

  // Link-domain state, clocked by the serial clock pin.
  logic              rq_s1_q;
  logic              rq_s2_q;
  logic              ld_req_q,    ld_req_d;
  logic [DATA_W-1:0] tx_sh_q,     tx_sh_d;
  logic [BCNT_W-1:0] bcnt_q,      bcnt_d;
  logic [DATA_W-1:0] rx_sh_q,     rx_sh_d;
  logic [DATA_W-1:0] rx_byte_q,   rx_byte_d;
  logic              ack_q,       ack_d;
  logic              link_busy;
  logic              start_ok;

  // Reverses bit order so the link can always shift most significant first.
  function automatic logic [DATA_W-1:0] flip(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = BYTE_RST;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction : flip

  // One buffer port is shared, and the engine has priority over the CPU.
  sabt_buf_ram #(
    .AW    (ADDR_W),
    .DW    (DATA_W),
    .DEPTH (RAM_DEP)
  ) u_ram (
    .clk   (CLK),
    .en    (ram_en),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  // The engine owns the buffer in its unhalted load cycles and, with receive enabled, its store cycles; the CPU waits then.
  always_comb begin
    eng_rd     = (state_q == ST_LOAD) && !CPU_HALT;
    eng_wr     = (state_q == ST_STORE) && CFG.rx_enable;
    // Received bytes are turned back into buffer order before they are stored.
    rx_ordered = CFG.bit_order_sel ? flip(rx_byte_q) : rx_byte_q;
    ram_en     = eng_rd || eng_wr || CPU_REQ.req;
    ram_we     = eng_wr || (!eng_rd && CPU_REQ.req && CPU_REQ.we);
    ram_addr   = (eng_rd || eng_wr) ? addr_q : CPU_REQ.addr;
    ram_wdata  = eng_wr ? rx_ordered : CPU_REQ.wdata;
    CPU_WAIT   = CPU_REQ.req && (eng_rd || eng_wr);
    rvalid_d   = CPU_REQ.req && !CPU_REQ.we && !(eng_rd || eng_wr);
  end

  // Automatic transfer requires a transmitting or receiving direction.
  assign start_ok = CFG.iface_enable && CFG.auto_mode_sel
                    && (CFG.tx_enable || CFG.rx_enable);

  // Engine sequencer. Every byte follows a fixed walk: load it from the buffer,
  // hand it to the link, wait for the link to return it, store the reply if receive is enabled and
  // count the interval unless the block ends there. Halt and suspend are only looked at on byte boundaries,
  // so the link never sees a half-sent word.
  always_comb begin
    state_d    = state_q;
    addr_d     = addr_q;
    busy_d     = busy_q;
    irq_d      = 1'b0;
    susp_d     = susp_q || (SUSPEND_TRIGGER && busy_q);
    tx_hold_d  = tx_hold_q;
    req_d      = req_q;
    ivl_d      = ivl_q;
    unique case (state_q)
      ST_IDLE: begin
        // A start is taken only from idle, so a trigger during a transfer is ignored.
        susp_d = 1'b0;
        if (START_TRIGGER && start_ok) begin
          addr_d  = ADDR_RST;
          busy_d  = 1'b1;
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!CPU_HALT) begin
          state_d = ST_PUT;
        end
      end
      ST_PUT: begin
        // The byte is turned around here when least significant bit first is wanted.
        tx_hold_d = CFG.bit_order_sel ? flip(ram_rdata) : ram_rdata;
        req_d     = !req_q;
        state_d   = ST_SEND;
      end
      ST_SEND: begin
        // Request and acknowledge are toggle flags; once they agree again the
        // link has finished the byte and its received word is stable.
        if (ack_s2_q == req_q) begin
          state_d = ST_STORE;
        end
      end
      ST_STORE: begin
        // A suspension ends the block after this byte, and the counter then
        // shows how many bytes were moved, or zero if this byte was at the end pointer.
        if (addr_q == XFER_END_POINTER) begin
          if (CFG.repeat_sel && !susp_q) begin
            addr_d  = ADDR_RST;
            ivl_d   = XFER_INTERVAL_REG;
            state_d = ST_GAP;
          end else begin
            addr_d  = ADDR_RST;
            busy_d  = 1'b0;
            irq_d   = 1'b1;
            state_d = ST_IDLE;
          end
        end else begin
          addr_d = addr_q + ADDR_ONE;
          if (susp_q) begin
            busy_d  = 1'b0;
            irq_d   = 1'b1;
            state_d = ST_IDLE;
          end else begin
            ivl_d   = XFER_INTERVAL_REG;
            state_d = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        // A CPU request in the interval freezes the count, so a busy CPU
        // stretches the gap instead of losing its access.
        if (ivl_q == IVL_RST) begin
          if (!CPU_HALT) begin
            state_d = ST_LOAD;
          end
        end else if (!CPU_REQ.req) begin
          ivl_d = ivl_q - IVL_ONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    // Clearing the interface enable overrides the state, busy and suspend steps and stays silent.
    if (!CFG.iface_enable) begin
      state_d = ST_IDLE;
      busy_d  = 1'b0;
      irq_d   = 1'b0;
      susp_d  = 1'b0;
    end
    // A new completion wins over a software clear in the same cycle.
    irq_flag_d = irq_d || (irq_flag_q && !IRQ_FLAG_CLR);
  end

  // Plain state registers; every next value except the acknowledge synchroniser's is formed in the processes above.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q    <= ST_IDLE;
      addr_q     <= ADDR_RST;
      busy_q     <= 1'b0;
      irq_flag_q <= 1'b0;
      irq_q      <= 1'b0;
      susp_q     <= 1'b0;
      tx_hold_q  <= BYTE_RST;
      req_q      <= 1'b0;
      ivl_q      <= IVL_RST;
      rvalid_q   <= 1'b0;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      addr_q     <= addr_d;
      busy_q     <= busy_d;
      irq_flag_q <= irq_flag_d;
      irq_q      <= irq_d;
      susp_q     <= susp_d;
      tx_hold_q  <= tx_hold_d;
      req_q      <= req_d;
      ivl_q      <= ivl_d;
      rvalid_q   <= rvalid_d;
      ack_s1_q   <= ack_q;
      ack_s2_q   <= ack_s1_q;
    end
  end

  // Status outputs come straight from their registers; SI_RELEASED is decoded from the enable bits.
  assign XFER_IN_PROGRESS   = busy_q;
  assign XFER_ADDR_COUNTER  = addr_q;
  assign AUTO_XFER_IRQ_FLAG = irq_flag_q;
  assign AUTO_XFER_IRQ      = irq_q;
  assign CPU_RVALID         = rvalid_q;
  assign CPU_RDATA          = ram_rdata;
  assign SI_RELEASED        = !(CFG.iface_enable && CFG.rx_enable);

  // Link side. The byte handed over in tx_hold_q stays still from the request
  // toggle until the acknowledge returns, so the link may sample it freely.
  assign link_busy = (ld_req_q != ack_q);
  // A byte cut short by clearing the enable still needs its remaining serial
  // clocks; a later start is taken at once, even while the link is still busy.

  // Launch side of the link. The request toggle crosses through two flip-flops
  // on the falling serial clock; a new byte is only taken while the link is
  // idle, and each later falling edge moves the next bit to the output.
  always_comb begin
    ld_req_d = ld_req_q;
    tx_sh_d  = tx_sh_q;
    if (!link_busy && (rq_s2_q != ld_req_q)) begin
      ld_req_d = rq_s2_q;
      tx_sh_d  = tx_hold_q;
    end else if (link_busy && (bcnt_q != BCNT_RST)) begin
      tx_sh_d = {tx_sh_q[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge SERIAL_CLOCK_PIN or posedge RST) begin
    if (RST) begin
      rq_s1_q  <= 1'b0;
      rq_s2_q  <= 1'b0;
      ld_req_q <= 1'b0;
      tx_sh_q  <= BYTE_RST;
    end else begin
      rq_s1_q  <= req_q;
      rq_s2_q  <= rq_s1_q;
      ld_req_q <= ld_req_d;
      tx_sh_q  <= tx_sh_d;
    end
  end

  assign SERIAL_OUT_PIN = tx_sh_q[DATA_W-1];

  // Capture side of the link. Each rising serial clock takes one input bit; the
  // eighth completes the word and returns the acknowledge toggle, which the
  // engine picks up through its own two-stage synchroniser.
  always_comb begin
    bcnt_d    = bcnt_q;
    rx_sh_d   = rx_sh_q;
    rx_byte_d = rx_byte_q;
    ack_d     = ack_q;
    if (link_busy) begin
      rx_sh_d = {rx_sh_q[DATA_W-2:0], SERIAL_IN_PIN};
      bcnt_d  = bcnt_q + BCNT_ONE;
      if (bcnt_q == BCNT_LAST) begin
        rx_byte_d = {rx_sh_q[DATA_W-2:0], SERIAL_IN_PIN};
        ack_d     = ld_req_q;
        bcnt_d    = BCNT_RST;
      end
    end
  end

  // Both link processes are reset together with the rest of the block.
  always_ff @(posedge SERIAL_CLOCK_PIN or posedge RST) begin
    if (RST) begin
      bcnt_q    <= BCNT_RST;
      rx_sh_q   <= BYTE_RST;
      rx_byte_q <= BYTE_RST;
      ack_q     <= 1'b0;
    end else begin
      bcnt_q    <= bcnt_d;
      rx_sh_q   <= rx_sh_d;
      rx_byte_q <= rx_byte_d;
      ack_q     <= ack_d;
    end
  end

endmodule : sabt_top
`default_nettype wire

// >>> verification/sabt_link_partner.sv
// Serial master model that clocks the link and echoes the output inverted.
`timescale 1ns/1ps
`default_nettype none
module sabt_link_partner (
  // Control.
  input wire logic     run,
  // Link pins.
  output logic         sck,
  output logic         si,
  input wire logic     so,
  // Output bits seen so far.
  output logic [127:0] hist
);
  // The clock only stops high, so no half pulse reaches the link.
  initial begin
    sck = 1'b1;
    #7;
    forever begin
      #62.5;
      if (run || !sck) begin
        sck = ~sck;
      end
    end
  end
  always @(posedge sck) begin
    hist <= {hist[126:0], so};
  end
  assign si = ~so;
endmodule : sabt_link_partner
`default_nettype wire

// >>> verification/sabt_top_monitor.sv
// Port checker of the serial block-transfer unit.
`timescale 1ns/1ps
`default_nettype none
module sabt_top_monitor (
  // Clock, reset and controls.
  input wire logic                        CLK,
  input wire logic                        RST,
  input wire sabt_pkg::sabt_cfg_s         CFG,
  input wire logic                        START_TRIGGER,
  input wire logic                        SUSPEND_TRIGGER,
  // Status.
  input wire logic                        SI_RELEASED,
  input wire logic                        XFER_IN_PROGRESS,
  input wire logic [sabt_pkg::ADDR_W-1:0] XFER_ADDR_COUNTER,
  input wire logic                        AUTO_XFER_IRQ_FLAG,
  input wire logic                        AUTO_XFER_IRQ
);
  import sabt_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  AST_START: assert property (!XFER_IN_PROGRESS && START_TRIGGER && CFG.iface_enable && CFG.auto_mode_sel
    && CFG.tx_enable |=> XFER_IN_PROGRESS && XFER_ADDR_COUNTER == ADDR_RST) else $error("start not taken");
  AST_IRQ_PULSE: assert property (AUTO_XFER_IRQ |-> AUTO_XFER_IRQ_FLAG && !XFER_IN_PROGRESS ##1 !AUTO_XFER_IRQ)
    else $error("bad end pulse");
  AST_END_IRQ: assert property ($fell(XFER_IN_PROGRESS) && $past(CFG.iface_enable) |-> AUTO_XFER_IRQ)
    else $error("end without pulse");
  AST_STOP: assert property (XFER_IN_PROGRESS && !CFG.iface_enable |=> !XFER_IN_PROGRESS && !AUTO_XFER_IRQ)
    else $error("disable not silent");
  AST_REPEAT: assert property (XFER_IN_PROGRESS && CFG.repeat_sel && XFER_ADDR_COUNTER == ADDR_RST
    && $past(XFER_ADDR_COUNTER) != ADDR_RST |-> !AUTO_XFER_IRQ) else $error("repeat wrap raised pulse");
  AST_STEP: assert property (XFER_IN_PROGRESS && $changed(XFER_ADDR_COUNTER) && XFER_ADDR_COUNTER != ADDR_RST
    |-> XFER_ADDR_COUNTER == $past(XFER_ADDR_COUNTER) + ADDR_ONE) else $error("counter skipped");
  AST_RELEASE: assert property (SI_RELEASED == !(CFG.iface_enable && CFG.rx_enable))
    else $error("input pin release wrong");
  AST_SUSPEND: assert property (SUSPEND_TRIGGER && XFER_IN_PROGRESS && CFG.iface_enable
    |-> ##[1:1000] !XFER_IN_PROGRESS) else $error("suspend never ended");
endmodule : sabt_top_monitor
bind sabt_top sabt_top_monitor u_mon (.CLK(CLK), .RST(RST), .CFG(CFG), .START_TRIGGER(START_TRIGGER),
  .SUSPEND_TRIGGER(SUSPEND_TRIGGER), .SI_RELEASED(SI_RELEASED), .XFER_IN_PROGRESS(XFER_IN_PROGRESS),
  .XFER_ADDR_COUNTER(XFER_ADDR_COUNTER), .AUTO_XFER_IRQ_FLAG(AUTO_XFER_IRQ_FLAG), .AUTO_XFER_IRQ(AUTO_XFER_IRQ));
`default_nettype wire

// >>> verification/test_serial_auto_block_transfer.sv
// Self-checking bench of the serial block-transfer unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module test_serial_auto_block_transfer;
  import sabt_pkg::*;
  logic CLK = 1'b0, RST = 1'b1, START_TRIGGER = 1'b0, SUSPEND_TRIGGER = 1'b0, CPU_HALT = 1'b0, IRQ_FLAG_CLR = 1'b0;
  logic SCK, SI, SO, SI_RELEASED, CPU_WAIT, CPU_RVALID, XFER_IN_PROGRESS, AUTO_XFER_IRQ_FLAG, AUTO_XFER_IRQ;
  logic [7:0] CPU_RDATA, rd, XFER_INTERVAL_REG = 8'h00;
  logic [4:0] XFER_ADDR_COUNTER, XFER_END_POINTER = 5'h00, hold;
  sabt_cfg_s CFG = '0;
  sabt_cpu_req_s CPU_REQ = '0;
  logic [127:0] hist;
  logic [7:0] mem [4];
  int bad_count = 0, comparisons = 0, seed = 32'h4dcfa1fd, n, k, m;
  always #12.5 CLK = ~CLK;
  sabt_top uut (.CLK(CLK), .RST(RST), .SERIAL_CLOCK_PIN(SCK), .SERIAL_IN_PIN(SI), .SERIAL_OUT_PIN(SO),
    .SI_RELEASED(SI_RELEASED), .CFG(CFG), .START_TRIGGER(START_TRIGGER), .SUSPEND_TRIGGER(SUSPEND_TRIGGER),
    .XFER_END_POINTER(XFER_END_POINTER), .XFER_INTERVAL_REG(XFER_INTERVAL_REG), .CPU_HALT(CPU_HALT),
    .CPU_REQ(CPU_REQ), .CPU_WAIT(CPU_WAIT), .CPU_RVALID(CPU_RVALID), .CPU_RDATA(CPU_RDATA),
    .XFER_IN_PROGRESS(XFER_IN_PROGRESS), .XFER_ADDR_COUNTER(XFER_ADDR_COUNTER),
    .AUTO_XFER_IRQ_FLAG(AUTO_XFER_IRQ_FLAG), .AUTO_XFER_IRQ(AUTO_XFER_IRQ), .IRQ_FLAG_CLR(IRQ_FLAG_CLR));
  sabt_link_partner peer (.run(XFER_IN_PROGRESS | RST), .sck(SCK), .si(SI), .so(SO), .hist(hist));
  task automatic results();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic fail_wait();
    bad_count++;
    $display("[FAIL] wait expected done seen timeout");
    results();
  endtask : fail_wait
  task automatic pulse(input int which);
    if (which == 0) START_TRIGGER = 1'b1;
    else if (which == 1) SUSPEND_TRIGGER = 1'b1;
    else IRQ_FLAG_CLR = 1'b1;
    @(negedge CLK);
    START_TRIGGER = 1'b0;
    SUSPEND_TRIGGER = 1'b0;
    IRQ_FLAG_CLR = 1'b0;
  endtask : pulse
  // Waits for the end pulse (cnt 0) or for the counter to reach v.
  task automatic wait_for(input int cnt, input logic [4:0] v);
    int w;
    w = 0;
    while (cnt ? XFER_ADDR_COUNTER !== v : AUTO_XFER_IRQ !== 1'b1) begin
      w++;
      if (w > 4000) fail_wait();
      @(negedge CLK);
    end
  endtask : wait_for
  task automatic cpu(input logic we, input logic [4:0] a, input logic [7:0] d);
    int w;
    w = 0;
    @(negedge CLK);
    CPU_REQ = '{1'b1, we, a, d};
    #1;
    while (CPU_WAIT !== 1'b0) begin
      w++;
      if (w > 200) fail_wait();
      @(negedge CLK);
      #1;
    end
    @(negedge CLK);
    CPU_REQ.req = 1'b0;
    rd = CPU_RDATA;
    if (!we) `CHK("read valid", 1'b1, CPU_RVALID)
  endtask : cpu
  function automatic logic [7:0] wire_order(input logic [7:0] b, input logic lsb);
    for (int i = 0; i < 8; i++) wire_order[i] = lsb ? b[7-i] : b[i];
  endfunction : wire_order
  function automatic logic seen(input logic [127:0] h, input logic [7:0] p);
    seen = 1'b0;
    for (int i = 0; i < 121; i++) if (h[i+:8] === p) seen = 1'b1;
  endfunction : seen
  initial begin
    repeat (16) @(negedge CLK);
    RST = 1'b0;
    `CHK("busy after reset", 1'b0, XFER_IN_PROGRESS)
    `CHK("counter after reset", 5'h00, XFER_ADDR_COUNTER)
    // Full duplex MSB first, transmit only LSB first, and a one-byte block.
    for (m = 0; m < 3; m++) begin
      n = (m == 2) ? 1 : (m == 1) ? 4 : 1 + ($unsigned($random(seed)) % 3);
      for (k = 0; k < n; k++) begin
        mem[k] = 8'($random(seed));
        cpu(1'b1, k[4:0], mem[k]);
      end
      XFER_END_POINTER = n[4:0] - 5'h01;
      XFER_INTERVAL_REG = 8'($random(seed)) & 8'h07;
      CFG = '{1'b1, 1'b1, 1'b0, 1'b1, m != 1, m != 0};
      pulse(0);
      wait_for(0, 5'h00);
      `CHK("busy at end", 1'b0, XFER_IN_PROGRESS)
      `CHK("counter at end", 5'h00, XFER_ADDR_COUNTER)
      `CHK("flag at end", 1'b1, AUTO_XFER_IRQ_FLAG)
      `CHK("input released", m == 1, SI_RELEASED)
      pulse(2);
      `CHK("flag cleared", 1'b0, AUTO_XFER_IRQ_FLAG)
      for (k = 0; k < n; k++) begin
        cpu(1'b0, k[4:0], 8'h00);
        `CHK("buffer byte", m == 1 ? mem[k] : ~mem[k], rd)
        `CHK("serial order", 1'b1, seen(hist, wire_order(mem[k], m != 0)))
      end
      $display("Block test %0d done", m);
    end
    CFG = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    XFER_END_POINTER = 5'h01;
    pulse(0);
    wait_for(1, 5'h01);
    wait_for(1, 5'h00);
    `CHK("repeat busy", 1'b1, XFER_IN_PROGRESS)
    `CHK("repeat flag", 1'b0, AUTO_XFER_IRQ_FLAG)
    // CPU reads that run into engine loads and intervals during the transfer.
    for (k = 0; k < 60; k++) begin
      cpu(1'b0, 5'h01, 8'h00);
      `CHK("read during run", mem[1], rd)
    end
    CPU_HALT = 1'b1;
    repeat (150) @(negedge CLK);
    hold = XFER_ADDR_COUNTER;
    repeat (100) @(negedge CLK);
    `CHK("halted counter", hold, XFER_ADDR_COUNTER)
    CPU_HALT = 1'b0;
    wait_for(1, hold ^ 5'h01);
    pulse(1);
    wait_for(0, 5'h00);
    `CHK("suspend busy", 1'b0, XFER_IN_PROGRESS)
    `CHK("suspend flag", 1'b1, AUTO_XFER_IRQ_FLAG)
    pulse(2);
    $display("Repeat test done");
    CFG = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    XFER_END_POINTER = 5'h03;
    pulse(0);
    repeat (30) @(negedge CLK);
    CFG.iface_enable = 1'b0;
    repeat (2) @(negedge CLK);
    `CHK("disable busy", 1'b0, XFER_IN_PROGRESS)
    `CHK("disable flag", 1'b0, AUTO_XFER_IRQ_FLAG)
    pulse(0);
    repeat (2) @(negedge CLK);
    `CHK("start refused", 1'b0, XFER_IN_PROGRESS)
    $display("Disable test done");
    results();
  end
endmodule : test_serial_auto_block_transfer
`default_nettype wire
